// File: core/can_sfr_pkg.sv
// Constants for the CAN register map on the host special-function bus.
// Assumes byte-wide SFR accesses qualified by the current SFR page.
package can_sfr_pkg;

  // SFR page that holds every CAN register
  localparam logic [7:0] CAN_PAGE = 8'h0c;

  // Byte addresses (low byte of each 16-bit register; control, status, test control, prescaler extension and clock config are single bytes)
  localparam logic [7:0] A_CLK_CONFIG = 8'h92;
  localparam logic [7:0] A_STATUS = 8'h94;
  localparam logic [7:0] A_ERROR_COUNTER = 8'h96;
  localparam logic [7:0] A_BIT_TIMING = 8'h9a;
  localparam logic [7:0] A_INTERRUPT_ID = 8'h9c;
  localparam logic [7:0] A_TEST_CONTROL = 8'h9e;
  localparam logic [7:0] A_PRESCALER_EXT = 8'ha1;
  localparam logic [7:0] A_TX_REQUEST_LO = 8'ha2;
  localparam logic [7:0] A_TX_REQUEST_HI = 8'ha4;
  localparam logic [7:0] A_NEW_DATA_LO = 8'haa;
  localparam logic [7:0] A_NEW_DATA_HI = 8'hac;
  localparam logic [7:0] A_IRQ_PENDING_LO = 8'hae;
  localparam logic [7:0] A_IRQ_PENDING_HI = 8'hb2;
  localparam logic [7:0] A_MSG_VALID_LO = 8'hba;
  localparam logic [7:0] A_MSG_VALID_HI = 8'hbc;
  localparam logic [7:0] A_CONTROL = 8'hc0;

  // Interface sets: command request, command mask, mask lo/hi, arbitration lo/hi,
  // message control, data A lo/hi, data B lo/hi
  localparam int IF_SETS = 2;
  localparam int IF_REGS = 11;
  localparam logic [7:0] IF_ADDR [IF_SETS][IF_REGS] = '{
    '{8'hbe, 8'hc2, 8'hc4, 8'hc6, 8'hca, 8'hcc, 8'hd2, 8'hd4, 8'hd6, 8'hda, 8'hdc},
    '{8'hde, 8'he2, 8'hea, 8'hec, 8'hee, 8'hf2, 8'hce, 8'hf6, 8'hfa, 8'hfc, 8'hfe}};
  localparam logic [3:0] IF_CMD_REQUEST = 4'h0;
  localparam logic [3:0] IF_CMD_MASK = 4'h1;
  localparam logic [3:0] IF_MASK_LO = 4'h2;
  localparam logic [3:0] IF_MASK_HI = 4'h3;

  // Message RAM layout: interface registers from mask lo upward are stored
  localparam int NUM_OBJECTS = 32;
  localparam logic [3:0] RAM_WORDS = 4'h9;
  localparam logic [3:0] RAM_WORD_OFS = 4'h2;

  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h01;
  localparam logic [15:0] RST_BIT_TIMING = 16'h2301;
  localparam logic [15:0] RST_CMD_REQUEST = 16'h0001;
  localparam logic [15:0] RST_MASK = 16'hffff;

  // Field positions
  localparam int CTL_CCE = 6;
  localparam int CTL_TEST = 7;
  localparam logic [7:0] TST_WR_MASK = 8'h7c;
  localparam int CREQ_BUSY = 15;
  localparam int CREQ_NUM_W = 6;
  localparam int CM_WRITE = 7;
  localparam int CM_MASK = 6;
  localparam int CM_ARB = 5;
  localparam int CM_CONTROL = 4;
  localparam int CM_DATA_A = 1;
  localparam int CM_DATA_B = 0;
  localparam int CLK_DIV_W = 2;

  // Transfer sequencer
  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_XFER = 1'b1
  } seq_state_t;

endpackage

// File: core/can_msg_ram.sv
// Message object store: one word per interface field from mask lo upward, per object.
// Assumes the caller keeps word below the word count; single port, read in one cycle.
`timescale 1ns/10ps
`default_nettype none
module can_msg_ram #(
  parameter int NUM_OBJ = 32,
  parameter int WORDS = 9,
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Access port
  input wire logic we,
  input wire logic [4:0] obj,
  input wire logic [3:0] word,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [NUM_OBJ][WORDS];

  // Object contents are unreset, as in any RAM
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[obj][word] <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (word < 4'(WORDS)) begin
      rdata <= mem[obj][word];
    end else begin
      rdata <= '0;
    end
  end

endmodule
`default_nettype wire

// File: core/can_sfr_register_map.sv
// CAN register bank on the host SFR bus, with two message interface sets.
// Assumes byte SFR strobes lasting one cycle and a protocol engine outside.
//
// Operation
// - CAN registers decode only while the SFR page is 0x0c.
// - Two independent interface sets reach any of the 32 message objects.
// - Objects hold mask, arbitration, message control and data A/B words.
// - Message RAM is reached only through the interface sets.
// - Handler registers are read-only and report per-object engine state.
// - Each 16-bit register is a low and high byte SFR pair.
// - Bit timing and prescaler extension write only while config change enabled.
// - Test register writes only while test mode enabled.
// - Test register top bit shows receive pin; other bits reset zero.
// - Reset loads control, bit timing, command requests, masks; rest zero.
// - Extra clock configuration register selects the CAN clock.
// - Protocol registers give control, interrupt, status and test access.
// - Writing an object number to a command request starts the transfer.
// - Divider codes 00 to 11 give system clock over 1, 2, 4, 8.
`timescale 1ns/10ps
`default_nettype none
module can_sfr_register_map (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Host SFR bus
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Protocol engine state
  input wire logic can_rx,
  input wire logic [15:0] err_count,
  input wire logic [15:0] int_id,
  input wire logic [31:0] tx_request,
  input wire logic [31:0] new_data,
  input wire logic [31:0] irq_pending,
  input wire logic [31:0] msg_valid,
  // Protocol engine configuration
  output logic [7:0] control_out,
  output logic [7:0] status_out,
  output logic [15:0] bit_timing_out,
  output logic [7:0] prescaler_out,
  output logic [7:0] test_out,
  output logic can_clk_en
);

  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] stat;
    logic [15:0] bt;
    logic [7:0] tst;
    logic [7:0] brpe;
    logic [1:0] clkdiv;
    logic [2:0] div_cnt;
    logic [1:0][10:0][15:0] ifr;
    can_sfr_pkg::seq_state_t seq;
    logic seq_set;
    logic [3:0] seq_cnt;
    logic [7:0] rdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic pg_ok;
  logic ram_we;
  logic [4:0] ram_obj;
  logic [3:0] ram_word;
  logic [15:0] ram_wdata;
  logic [15:0] ram_rdata;
  logic [15:0] cur_cmask;
  logic [15:0] cur_creq;

  function automatic logic [15:0] wr_byte(input logic [15:0] old, input logic hi,
                                         input logic [7:0] d);
    wr_byte = hi ? {d, old[7:0]} : {old[15:8], d};
  endfunction

  function automatic logic group_sel(input logic [15:0] cm, input logic [3:0] w);
    case (w)
      4'h0, 4'h1: group_sel = cm[can_sfr_pkg::CM_MASK];
      4'h2, 4'h3: group_sel = cm[can_sfr_pkg::CM_ARB];
      4'h4: group_sel = cm[can_sfr_pkg::CM_CONTROL];
      4'h5, 4'h6: group_sel = cm[can_sfr_pkg::CM_DATA_A];
      4'h7, 4'h8: group_sel = cm[can_sfr_pkg::CM_DATA_B];
      default: group_sel = 1'b0;
    endcase
  endfunction

  // Returns {hit, set, index} for an interface register byte address
  function automatic logic [5:0] if_decode(input logic [7:0] a);
    logic [5:0] r;
    r = '0;
    for (int s = 0; s < can_sfr_pkg::IF_SETS; s++) begin
      for (int i = 0; i < can_sfr_pkg::IF_REGS; i++) begin
        if ({a[7:1], 1'b0} == can_sfr_pkg::IF_ADDR[s][i]) begin
          r = {1'b1, 1'(s), 4'(i)};
        end
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'h0: div_mask = 3'h0;
      2'h1: div_mask = 3'h1;
      2'h2: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  assign pg_ok = (sfr_page == can_sfr_pkg::CAN_PAGE);

  assign cur_creq = st_ff.ifr[st_ff.seq_set][can_sfr_pkg::IF_CMD_REQUEST];
  assign cur_cmask = st_ff.ifr[st_ff.seq_set][can_sfr_pkg::IF_CMD_MASK];

  // Message RAM port driven only by the sequencer
  always_comb begin
    ram_obj = 5'(cur_creq[can_sfr_pkg::CREQ_NUM_W-1:0] - 6'h01);
    ram_word = st_ff.seq_cnt;
    ram_wdata = '0;
    ram_we = 1'b0;
    if (st_ff.seq == can_sfr_pkg::SEQ_XFER && st_ff.seq_cnt < can_sfr_pkg::RAM_WORDS) begin
      ram_wdata = st_ff.ifr[st_ff.seq_set][4'(st_ff.seq_cnt + can_sfr_pkg::RAM_WORD_OFS)];
      ram_we = cur_cmask[can_sfr_pkg::CM_WRITE] && group_sel(cur_cmask, st_ff.seq_cnt);
    end
  end

  can_msg_ram #(
    .NUM_OBJ(can_sfr_pkg::NUM_OBJECTS),
    .WORDS(9),
    .WIDTH(16)
  ) u_ram (
    .mclk(mclk),
    .rst_n(rst_n),
    .we(ram_we),
    .obj(ram_obj),
    .word(ram_word),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  always_comb begin
    logic [5:0] ifd;
    logic [7:0] key;
    logic [15:0] v16;
    logic [7:0] rv;
    logic [3:0] prev;
    ifd = if_decode(sfr_addr);
    key = {sfr_addr[7:1], 1'b0};
    v16 = '0;
    rv = '0;
    prev = 4'(st_ff.seq_cnt - 4'h1);
    nxt_st = st_ff;
    nxt_st.div_cnt = 3'(st_ff.div_cnt + 3'h1);
    // Host writes
    if (sfr_wr && pg_ok) begin
      if (sfr_addr == can_sfr_pkg::A_CONTROL) begin
        nxt_st.ctl = sfr_wdata;
      end else if (sfr_addr == can_sfr_pkg::A_STATUS) begin
        nxt_st.stat = sfr_wdata;
      end else if (sfr_addr == can_sfr_pkg::A_TEST_CONTROL) begin
        if (st_ff.ctl[can_sfr_pkg::CTL_TEST]) begin
          nxt_st.tst = sfr_wdata & can_sfr_pkg::TST_WR_MASK;
        end
      end else if (sfr_addr == can_sfr_pkg::A_PRESCALER_EXT) begin
        if (st_ff.ctl[can_sfr_pkg::CTL_CCE]) begin
          nxt_st.brpe = sfr_wdata;
        end
      end else if (sfr_addr == can_sfr_pkg::A_CLK_CONFIG) begin
        nxt_st.clkdiv = sfr_wdata[can_sfr_pkg::CLK_DIV_W-1:0];
      end else if (key == can_sfr_pkg::A_BIT_TIMING) begin
        if (st_ff.ctl[can_sfr_pkg::CTL_CCE]) begin
          nxt_st.bt = wr_byte(st_ff.bt, sfr_addr[0], sfr_wdata);
        end
      // Interface set writes, held off while busy
      end else if (ifd[5] && !st_ff.ifr[ifd[4]][0][can_sfr_pkg::CREQ_BUSY]) begin
        nxt_st.ifr[ifd[4]][ifd[3:0]] =
          wr_byte(st_ff.ifr[ifd[4]][ifd[3:0]], sfr_addr[0], sfr_wdata);
        // Low byte of command request starts a transfer
        if (ifd[3:0] == can_sfr_pkg::IF_CMD_REQUEST) begin
          nxt_st.ifr[ifd[4]][0][can_sfr_pkg::CREQ_BUSY] = !sfr_addr[0];
        end
      end
    end
    case (st_ff.seq)
      can_sfr_pkg::SEQ_IDLE: begin
        nxt_st.seq_cnt = 4'h0;
        if (st_ff.ifr[0][0][can_sfr_pkg::CREQ_BUSY]) begin
          nxt_st.seq = can_sfr_pkg::SEQ_XFER;
          nxt_st.seq_set = 1'b0;
        end else if (st_ff.ifr[1][0][can_sfr_pkg::CREQ_BUSY]) begin
          nxt_st.seq = can_sfr_pkg::SEQ_XFER;
          nxt_st.seq_set = 1'b1;
        end
      end
      can_sfr_pkg::SEQ_XFER: begin
        nxt_st.seq_cnt = 4'(st_ff.seq_cnt + 4'h1);
        if (st_ff.seq_cnt != 4'h0 && !cur_cmask[can_sfr_pkg::CM_WRITE]
            && group_sel(cur_cmask, prev)) begin
          nxt_st.ifr[st_ff.seq_set][4'(prev + can_sfr_pkg::RAM_WORD_OFS)] = ram_rdata;
        end
        if (st_ff.seq_cnt == can_sfr_pkg::RAM_WORDS) begin
          nxt_st.ifr[st_ff.seq_set][0][can_sfr_pkg::CREQ_BUSY] = 1'b0;
          nxt_st.seq = can_sfr_pkg::SEQ_IDLE;
        end
      end
      default: begin
        nxt_st.seq = can_sfr_pkg::SEQ_IDLE;
      end
    endcase
    if (key == can_sfr_pkg::A_ERROR_COUNTER) begin
      v16 = err_count;
    end else if (key == can_sfr_pkg::A_BIT_TIMING) begin
      v16 = st_ff.bt;
    end else if (key == can_sfr_pkg::A_INTERRUPT_ID) begin
      v16 = int_id;
    end else if (key == can_sfr_pkg::A_TX_REQUEST_LO) begin
      v16 = tx_request[15:0];
    end else if (key == can_sfr_pkg::A_TX_REQUEST_HI) begin
      v16 = tx_request[31:16];
    end else if (key == can_sfr_pkg::A_NEW_DATA_LO) begin
      v16 = new_data[15:0];
    end else if (key == can_sfr_pkg::A_NEW_DATA_HI) begin
      v16 = new_data[31:16];
    end else if (key == can_sfr_pkg::A_IRQ_PENDING_LO) begin
      v16 = irq_pending[15:0];
    end else if (key == can_sfr_pkg::A_IRQ_PENDING_HI) begin
      v16 = irq_pending[31:16];
    end else if (key == can_sfr_pkg::A_MSG_VALID_LO) begin
      v16 = msg_valid[15:0];
    end else if (key == can_sfr_pkg::A_MSG_VALID_HI) begin
      v16 = msg_valid[31:16];
    end else if (ifd[5]) begin
      v16 = st_ff.ifr[ifd[4]][ifd[3:0]];
    end
    if (sfr_addr == can_sfr_pkg::A_CONTROL) begin
      rv = st_ff.ctl;
    end else if (sfr_addr == can_sfr_pkg::A_STATUS) begin
      rv = st_ff.stat;
    // Live receive pin in top bit
    end else if (sfr_addr == can_sfr_pkg::A_TEST_CONTROL) begin
      rv = {can_rx, st_ff.tst[6:0]};
    end else if (sfr_addr == can_sfr_pkg::A_PRESCALER_EXT) begin
      rv = st_ff.brpe;
    end else if (sfr_addr == can_sfr_pkg::A_CLK_CONFIG) begin
      rv = {6'h00, st_ff.clkdiv};
    end else begin
      rv = sfr_addr[0] ? v16[15:8] : v16[7:0];
    end
    if (sfr_rd && pg_ok) begin
      nxt_st.rdata = rv;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.ctl <= can_sfr_pkg::RST_CONTROL;
      st_ff.bt <= can_sfr_pkg::RST_BIT_TIMING;
      for (int s = 0; s < can_sfr_pkg::IF_SETS; s++) begin
        st_ff.ifr[s][can_sfr_pkg::IF_CMD_REQUEST] <= can_sfr_pkg::RST_CMD_REQUEST;
        st_ff.ifr[s][can_sfr_pkg::IF_MASK_LO] <= can_sfr_pkg::RST_MASK;
        st_ff.ifr[s][can_sfr_pkg::IF_MASK_HI] <= can_sfr_pkg::RST_MASK;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sfr_rdata = st_ff.rdata;
  assign control_out = st_ff.ctl;
  assign status_out = st_ff.stat;
  assign bit_timing_out = st_ff.bt;
  assign prescaler_out = st_ff.brpe;
  assign test_out = st_ff.tst;
  assign can_clk_en = ((st_ff.div_cnt & div_mask(st_ff.clkdiv)) == div_mask(st_ff.clkdiv));

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic ifa_busy;
  logic ifb_busy;
  assign ifa_busy = st_ff.ifr[0][0][can_sfr_pkg::CREQ_BUSY];
  assign ifb_busy = st_ff.ifr[1][0][can_sfr_pkg::CREQ_BUSY];

  a_page_gate_wr: assert property (
    (sfr_wr && !pg_ok) |=> $stable(control_out) && $stable(status_out))
    else $error("write outside CAN page changed a register");
  a_cce_gate_bt: assert property (
    (sfr_wr && pg_ok && sfr_addr == can_sfr_pkg::A_BIT_TIMING && !control_out[6])
    |=> $stable(bit_timing_out))
    else $error("bit timing written without config change enable");
  a_cce_gate_brpe: assert property (
    (sfr_wr && pg_ok && sfr_addr == can_sfr_pkg::A_PRESCALER_EXT && !control_out[6])
    |=> $stable(prescaler_out))
    else $error("prescaler written without config change enable");
  a_test_gate_wr: assert property (
    (sfr_wr && pg_ok && sfr_addr == can_sfr_pkg::A_TEST_CONTROL && !control_out[7])
    |=> $stable(test_out))
    else $error("test register written without test enable");
  a_test_rx_read: assert property (
    (sfr_rd && pg_ok && sfr_addr == can_sfr_pkg::A_TEST_CONTROL)
    |=> sfr_rdata == {$past(can_rx), $past(test_out[6:0])})
    else $error("test register read does not show receive pin");
  a_reset_values: assert property (
    $rose(rst_n) |-> control_out == 8'h01 && bit_timing_out == 16'h2301
    && test_out == 8'h00 && st_ff.ifr[1][2] == 16'hffff && st_ff.ifr[0][0] == 16'h0001)
    else $error("wrong value after reset");
  a_bt_high_byte: assert property (
    (sfr_rd && pg_ok && sfr_addr == 8'h9b) |=> sfr_rdata == $past(bit_timing_out[15:8]))
    else $error("bit timing high byte read wrong");
  a_handler_read: assert property (
    (sfr_rd && pg_ok && sfr_addr == can_sfr_pkg::A_TX_REQUEST_HI)
    |=> sfr_rdata == $past(tx_request[23:16]))
    else $error("transmission request read wrong");
  a_xfer_busy_ends: assert property (
    (sfr_wr && pg_ok && sfr_addr == 8'hbe && !ifa_busy) |=> ifa_busy ##[1:24] !ifa_busy)
    else $error("command request transfer did not complete");
  a_clk_div_one: assert property (
    (st_ff.clkdiv == 2'h0) |-> can_clk_en)
    else $error("divide by one must tick every cycle");
  a_clk_div_two: assert property (
    (st_ff.clkdiv == 2'h1 && can_clk_en && !sfr_wr) |=> !can_clk_en ##1 can_clk_en)
    else $error("divide by two tick spacing wrong");
  a_ram_idle_quiet: assert property (
    (st_ff.seq == can_sfr_pkg::SEQ_IDLE) |-> !ram_we)
    else $error("message RAM written outside a transfer");

  c_ifa_write_xfer: cover property (
    ifa_busy && cur_cmask[7] && ram_we ##[1:12] !ifa_busy);
  c_ifb_read_xfer: cover property (
    ifb_busy && st_ff.seq_set && !cur_cmask[7] ##[1:12] !ifb_busy);
  c_gated_bt: cover property (
    sfr_wr && pg_ok && sfr_addr == can_sfr_pkg::A_BIT_TIMING && !control_out[6]);
  c_div_eight: cover property (st_ff.clkdiv == 2'h3 && can_clk_en);

endmodule
`default_nettype wire

// File: testbench/can_host_model.sv
// Host processor model: issues byte reads and writes on the SFR bus.
// Assumes one clock; tasks are called from the testbench by hierarchical name.
`timescale 1ns/10ps
`default_nettype none
module can_host_model (
  // Clock
  input wire logic mclk,
  // SFR bus
  output logic [7:0] sfr_page,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata
);
  logic [1:0] div_sel;

  initial begin
    sfr_page = 8'h00;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    div_sel = 2'h0;
  end

  // Byte write, then the read-back wait for the slower of old and new divider
  task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk);
    sfr_page <= pg;
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge mclk);
    sfr_wr <= 1'b0;
    sfr_addr <= ~a;
    sfr_wdata <= ~d;
    n = (1 << div_sel) - 1;
    if (pg === can_sfr_pkg::CAN_PAGE && a === can_sfr_pkg::A_CLK_CONFIG) begin
      div_sel = d[1:0];
    end
    if (((1 << div_sel) - 1) > n) begin
      n = (1 << div_sel) - 1;
    end
    repeat (n) @(posedge mclk);
    // Let the register update of the last edge settle before the caller looks
    #1;
  endtask

  // Byte read; data is taken once the registered answer has settled
  task automatic rd(input logic [7:0] pg, input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    sfr_page <= pg;
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    sfr_addr <= ~a;
    @(posedge mclk);
    #1;
    d = sfr_rdata;
  endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking testbench for the CAN register bank.
// Assumes the host model drives the SFR bus and the bench drives engine inputs.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk;
  logic nrst;
  logic [7:0] sfr_page;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic can_rx;
  logic [15:0] err_count;
  logic [15:0] int_id;
  logic [31:0] tx_request;
  logic [31:0] new_data;
  logic [31:0] irq_pending;
  logic [31:0] msg_valid;
  logic [7:0] control_out;
  logic [7:0] status_out;
  logic [15:0] bit_timing_out;
  logic [7:0] prescaler_out;
  logic [7:0] test_out;
  logic can_clk_en;
  int err_total;
  int cmp_count;
  int cycles;
  int pulses;
  logic [7:0] v;

  can_sfr_register_map dut_u (
    .mclk(mclk), .nrst(nrst), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .can_rx(can_rx), .err_count(err_count), .int_id(int_id), .tx_request(tx_request),
    .new_data(new_data), .irq_pending(irq_pending), .msg_valid(msg_valid),
    .control_out(control_out), .status_out(status_out), .bit_timing_out(bit_timing_out),
    .prescaler_out(prescaler_out), .test_out(test_out), .can_clk_en(can_clk_en)
  );

  can_host_model host_u (
    .mclk(mclk), .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host_u.wr(can_sfr_pkg::CAN_PAGE, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(can_sfr_pkg::CAN_PAGE, a, v);
    chk({24'h0, v}, {24'h0, e});
  endtask

  // Poll the busy bit of a command request high byte, bounded
  task automatic wait_idle(input logic [7:0] a);
    int i;
    for (i = 0; i < 40; i++) begin
      host_u.rd(can_sfr_pkg::CAN_PAGE, a, v);
      if (v[7] === 1'b0) begin
        break;
      end
    end
    chk({31'h0, v[7]}, 32'h0);
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      tally_and_finish();
    end
  end

  initial begin
    err_total = 0;
    cmp_count = 0;
    cycles = 0;
    nrst = 1'b0;
    can_rx = 1'b1;
    err_count = 16'h1234;
    int_id = 16'h8001;
    tx_request = 32'h89ab_cdef;
    new_data = 32'h0102_0304;
    irq_pending = 32'h5a5a_a5a5;
    msg_valid = 32'hffff_0000;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    // Reset values and unmapped read
    chk({24'h0, control_out}, 32'h01);
    chk({16'h0, bit_timing_out}, 32'h2301);
    rchk(8'hc0, 8'h01);
    rchk(8'h9a, 8'h01);
    rchk(8'h9b, 8'h23);
    rchk(8'hbe, 8'h01);
    rchk(8'hde, 8'h01);
    rchk(8'hc5, 8'hff);
    rchk(8'hec, 8'hff);
    rchk(8'hca, 8'h00);
    rchk(8'h94, 8'h00);
    rchk(8'ha1, 8'h00);
    rchk(8'h9e, 8'h80);
    rchk(8'h98, 8'h00);
    // Engine state through read-only error counter, interrupt identifier and handler registers
    rchk(8'h96, 8'h34);
    rchk(8'h97, 8'h12);
    rchk(8'h9c, 8'h01);
    rchk(8'h9d, 8'h80);
    rchk(8'ha2, 8'hef);
    rchk(8'ha3, 8'hcd);
    rchk(8'ha4, 8'hab);
    rchk(8'ha5, 8'h89);
    rchk(8'haa, 8'h04);
    rchk(8'had, 8'h01);
    rchk(8'hae, 8'ha5);
    rchk(8'hb3, 8'h5a);
    rchk(8'hbd, 8'hff);
    w(8'ha2, 8'h00);
    rchk(8'ha2, 8'hef);
    // Wrong page is not decoded
    host_u.wr(8'h0b, 8'hc0, 8'h41);
    rchk(8'hc0, 8'h01);
    // Gated bit timing, prescaler and test writes
    w(8'h9a, 8'h55);
    w(8'ha1, 8'h0f);
    w(8'h9e, 8'h7c);
    chk({16'h0, bit_timing_out}, 32'h2301);
    chk({24'h0, prescaler_out}, 32'h00);
    chk({24'h0, test_out}, 32'h00);
    rchk(8'h9a, 8'h01);
    w(8'hc0, 8'hc1);
    chk({24'h0, control_out}, 32'hc1);
    w(8'h9a, 8'h55);
    w(8'h9b, 8'h66);
    w(8'ha1, 8'h0f);
    w(8'h9e, 8'hff);
    w(8'h94, 8'h07);
    @(posedge mclk);
    can_rx <= 1'b0;
    chk({16'h0, bit_timing_out}, 32'h6655);
    chk({24'h0, prescaler_out}, 32'h0f);
    chk({24'h0, test_out}, 32'h7c);
    chk({24'h0, status_out}, 32'h07);
    rchk(8'h9e, 8'h7c);
    // Set A writes object 5, set B reads it back
    w(8'hca, 8'h34);
    w(8'hcc, 8'h12);
    w(8'hd4, 8'ha5);
    w(8'hc2, 8'hf3);
    w(8'hbe, 8'h05);
    rchk(8'hbf, 8'h80);
    wait_idle(8'hbf);
    w(8'he2, 8'h73);
    w(8'hde, 8'h05);
    wait_idle(8'hdf);
    rchk(8'hee, 8'h34);
    rchk(8'hf2, 8'h12);
    rchk(8'hf6, 8'ha5);
    rchk(8'hea, 8'hff);
    // Clock divider codes and enable rate
    for (int c = 3; c >= 0; c--) begin
      w(8'h92, 8'hfc | 8'(c));
      rchk(8'h92, 8'(c));
      pulses = 0;
      repeat (16) begin
        @(posedge mclk);
        #1;
        if (can_clk_en === 1'b1) begin
          pulses = pulses + 1;
        end
      end
      chk(32'(pulses), 32'(16 >> c));
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
